/* File: verilog/chip_select_pkg.sv */
// Shared constants and types of the programmable chip-select decoder
`default_nettype none
package chip_select_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int NUM_SEL = 12;
	localparam logic [3:0] NUM_SEL_L = 4'hc;
	localparam logic [3:0] BOOT_IDX = 4'h0;
	localparam logic [3:0] FIRST_LATCH_IDX = 4'h4;
	localparam logic [3:0] LAST_LATCH_IDX = 4'ha;
	localparam logic [3:0] SLOW_CLK_IDX = 4'hb;

	// ****************************************************************
	// Register map, word addresses on the register port
	// ****************************************************************
	localparam logic [3:0] BASE_PAGE = 4'h0;
	localparam logic [3:0] OPT_PAGE = 4'h1;
	localparam logic [7:0] PINFN_LO_OFS = 8'h20;
	localparam logic [7:0] PINFN_HI_OFS = 8'h21;
	localparam logic [7:0] LATCH_OFS = 8'h22;
	localparam logic [7:0] STATUS_OFS = 8'h23;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int BASE_ADDR_LSB = 3;
	localparam int OPT_MODE_BIT = 15;
	localparam int OPT_BYTE_LSB = 13;
	localparam int OPT_RW_LSB = 11;
	localparam int OPT_STROBE_TIMING_SELECT_BIT = 10;
	localparam int OPT_ACK_LSB = 6;
	localparam int OPT_SPACE_LSB = 4;
	localparam int OPT_IPL_LSB = 1;
	localparam int OPT_AUTOVECTOR_ACK_BIT = 0;

	// ****************************************************************
	// Values after reset
	// ****************************************************************
	localparam logic [15:0] GEN_BASE_RST = 16'h0000;
	localparam logic [15:0] BOOT_BASE_RST = 16'h0007;
	localparam logic [15:0] GEN_OPT_RST = 16'h0000;
	localparam logic [15:0] BOOT_OPT_RST = 16'h7b60;
	localparam logic [6:0] LATCH_RST = 7'h00;

	// ****************************************************************
	// Encodings
	// ****************************************************************
	localparam logic [1:0] PF_LATCH = 2'h0;
	localparam logic [1:0] PF_ALT = 2'h1;
	localparam logic [1:0] PF_SEL8 = 2'h2;
	localparam logic [1:0] PF_SEL16 = 2'h3;
	localparam logic [1:0] SP_CPU = 2'h0;
	localparam logic [1:0] SP_USER = 2'h1;
	localparam logic [1:0] SP_SUP = 2'h2;
	localparam logic [1:0] SP_ANY = 2'h3;
	localparam logic [2:0] FC_CPU = 3'h7;
	localparam logic [3:0] IACK_TYPE = 4'hf;
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [3:0] ACK_FAST = 4'he;
	localparam logic [3:0] ACK_EXT_ONLY = 4'hf;

	// ****************************************************************
	// Timing, counted in system clocks of 40 ns
	// ****************************************************************
	localparam logic [2:0] SLOW_HALF_CYC = 3'h4;

	typedef enum logic [1:0] {
		ACK_IDLE = 2'b00,
		ACK_WAIT = 2'b01,
		ACK_TERM = 2'b10,
		ACK_AUTO = 2'b11
	} ack_state_t;

endpackage
`default_nettype wire

/* File: verilog/chip_select_decoder.sv */
// Programmable chip-select decoder with shared internal acknowledge
//
// Summary of operation
// - Base field compared over block-size bits
// - Block size codes 2K up to 1M
// - Upper four address bits copy bit 19
// - Boot select matches zero after reset
// - Mode bit: strobe timing or slow clock
// - Byte field enables per port width
// - General byte fields clear, boot both
// - Read/write field gates assertion
// - Strobe bit picks address or data strobe
// - Acknowledge field sets internal wait count
// - External acknowledges always pass through
// - Space field must match function code
// - Level field matches acknowledged priority
// - Autovector bit ends acknowledge cycles
// - Latch bits drive discrete pins, bit7 zero
// - All fields match before assertion
// - Assertion follows strobe or slow clock
// - Wait states until some acknowledge
// - Pin function code decode
// - On-chip hits never assert selects
// - Select outputs are active low
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module chip_select_decoder
	import chip_select_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic srst_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	// Processor bus, same clock
	input wire logic [23:0] addr_in,
	input wire logic [2:0] function_code_in,
	input wire logic read_in,
	input wire logic [1:0] transfer_size_in,
	input wire logic address_strobe_n_in,
	input wire logic data_strobe_n_in,
	input wire logic internal_hit_in,
	// Pins from outside
	input wire logic [7:0] data_strap_in,
	input wire logic [1:0] ext_transfer_ack_n_in,
	// Select pins and cycle termination
	output logic [11:0] select_n_out,
	output logic slow_bus_clock_out,
	output logic [1:0] transfer_ack_n_out,
	output logic autovector_ack_n_out
);

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	// Mask over address bits 23..11 for each block size code
	function automatic logic [12:0] block_mask(input logic [2:0] code);
		case (code)
			3'h0: block_mask = 13'h1fff;
			3'h1: block_mask = 13'h1ffc;
			3'h2: block_mask = 13'h1ff8;
			3'h3: block_mask = 13'h1fe0;
			3'h4: block_mask = 13'h1fc0;
			3'h5: block_mask = 13'h1f80;
			3'h6: block_mask = 13'h1f00;
			default: block_mask = 13'h1e00;
		endcase
	endfunction

	// Function code against the space field
	function automatic logic space_match(input logic [1:0] space, input logic [2:0] fc);
		logic user;
		logic sup;
		user = (fc == 3'h1) || (fc == 3'h2);
		sup = (fc == 3'h5) || (fc == 3'h6);
		case (space)
			SP_CPU: space_match = (fc == FC_CPU);
			SP_USER: space_match = user;
			SP_SUP: space_match = sup;
			default: space_match = user || sup;
		endcase
	endfunction

	// Wait states for an acknowledge code; the fast code means none
	function automatic logic [3:0] ack_waits(input logic [3:0] code);
		ack_waits = (code == ACK_FAST) ? 4'h0 : code;
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	logic [15:0] base_ff [NUM_SEL];
	logic [15:0] nxt_base [NUM_SEL];
	logic [15:0] opt_ff [NUM_SEL];
	logic [15:0] nxt_opt [NUM_SEL];
	logic [1:0] pf_ff [NUM_SEL];
	logic [1:0] nxt_pf [NUM_SEL];
	logic [6:0] latch_ff;
	logic [6:0] nxt_latch;
	logic [15:0] rdata_ff;
	logic [15:0] nxt_rdata;
	logic [9:0] sync1_ff;
	logic [9:0] sync2_ff;
	logic [9:0] sync3_ff;
	logic [9:0] accept_ff;
	logic [9:0] nxt_accept;
	logic [2:0] slow_cnt_ff;
	logic [2:0] nxt_slow_cnt;
	logic slow_clk_ff;
	logic nxt_slow_clk;
	ack_state_t state_ff;
	ack_state_t nxt_state;
	logic [3:0] wait_ff;
	logic [3:0] nxt_wait;
	logic [3:0] served_ff;
	logic [3:0] nxt_served;
	logic as_prev_ff;
	logic [11:0] sel_ff;
	logic [11:0] nxt_sel;
	logic [11:0] pin_ff;
	logic [11:0] nxt_pin;
	logic [23:0] eff_addr;
	logic as_act;
	logic ds_act;
	logic iack;
	logic upper_used;
	logic lower_used;
	logic [11:0] match;
	logic [11:0] rw_ok;
	logic [11:0] space_ok;
	logic [11:0] byte_ok;
	logic found;
	logic [3:0] pick;
	logic [1:0] int_ack_n;
	logic [11:0] latch_pins;

	// ****************************************************************
	// Bus qualifiers
	// ****************************************************************
	// The top nibble of the address is never decoded on its own
	assign eff_addr = {{4{addr_in[19]}}, addr_in[19:0]};
	assign as_act = ~address_strobe_n_in;
	assign ds_act = ~data_strobe_n_in;
	assign iack = (function_code_in == FC_CPU) && (addr_in[19:16] == IACK_TYPE);
	assign upper_used = ~addr_in[0];
	assign lower_used = addr_in[0] | (transfer_size_in != SIZE_BYTE);
	// Latch bits laid out by pin index, so no select indexes out of range
	assign latch_pins = {1'b1, latch_ff, 4'hf};

	// ****************************************************************
	// Per-select compare and pin drive
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < NUM_SEL; g++) begin : g_sel
			logic addr_ok;
			logic ipl_ok;
			logic [1:0] byte_f;
			logic [2:0] ipl_f;
			logic strobe_ok;
			assign byte_f = opt_ff[g][OPT_BYTE_LSB+:2];
			assign ipl_f = opt_ff[g][OPT_IPL_LSB+:3];
			// Only the bits above the block size take part
			assign addr_ok = ((eff_addr[23:11] ^ base_ff[g][15:BASE_ADDR_LSB])
				& block_mask(base_ff[g][2:0])) == 13'h0000;
			assign space_ok[g] = space_match(opt_ff[g][OPT_SPACE_LSB+:2], function_code_in);
			// Level field only matters for acknowledge cycles in CPU space
			assign ipl_ok = (opt_ff[g][OPT_SPACE_LSB+:2] != SP_CPU) || !iack
				|| (ipl_f == 3'h0) || (ipl_f == addr_in[3:1]);
			assign rw_ok[g] = read_in ? opt_ff[g][OPT_RW_LSB] : opt_ff[g][OPT_RW_LSB+1];
			assign byte_ok[g] = (pf_ff[g] == PF_SEL16)
				? ((byte_f[1] & upper_used) | (byte_f[0] & lower_used))
				: (byte_f != 2'h0);
			assign match[g] = addr_ok & space_ok[g] & ipl_ok & rw_ok[g] & byte_ok[g]
				& ~internal_hit_in;
			// Async follows the chosen strobe, sync waits for slow clock high
			assign strobe_ok = opt_ff[g][OPT_MODE_BIT] ? (as_act & slow_clk_ff)
				: (opt_ff[g][OPT_STROBE_TIMING_SELECT_BIT] ? ds_act : as_act);
			assign nxt_sel[g] = ~srst_in & match[g] & strobe_ok;
			always_comb begin
				case (pf_ff[g])
					PF_SEL8, PF_SEL16: nxt_pin[g] = ~nxt_sel[g];
					PF_LATCH: begin
						if (4'(g) == SLOW_CLK_IDX)
							nxt_pin[g] = nxt_slow_clk;
						else if (4'(g) >= FIRST_LATCH_IDX && 4'(g) <= LAST_LATCH_IDX)
							nxt_pin[g] = latch_pins[g];
						else
							nxt_pin[g] = 1'b1;
					end
					default: nxt_pin[g] = 1'b1;
				endcase
				if (srst_in)
					nxt_pin[g] = 1'b1;
			end
		end
	endgenerate

	// ****************************************************************
	// Pin input synchronisers
	// ****************************************************************
	// Straps and acknowledges share one filter; a bit moves only on agreement
	assign nxt_accept = (sync2_ff & sync3_ff) | (accept_ff & (sync2_ff | sync3_ff));

	// Data pipeline only, so no reset is needed here
	always_ff @(posedge clk_sys_in) begin
		sync1_ff <= {data_strap_in, ext_transfer_ack_n_in};
		sync2_ff <= sync1_ff;
		sync3_ff <= sync2_ff;
		accept_ff <= nxt_accept;
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	// Writes and reset values; straps are caught while reset is held
	always_comb begin
		nxt_base = base_ff;
		nxt_opt = opt_ff;
		nxt_pf = pf_ff;
		nxt_latch = latch_ff;
		if (srst_in) begin
			for (int i = 0; i < NUM_SEL; i++) begin
				nxt_base[i] = (i == 0) ? BOOT_BASE_RST : GEN_BASE_RST;
				nxt_opt[i] = (i == 0) ? BOOT_OPT_RST : GEN_OPT_RST;
				nxt_pf[i] = (i == 0) ? {1'b1, accept_ff[2]} : {accept_ff[2 + (i + 1) / 2], 1'b1};
			end
			nxt_latch = LATCH_RST;
		end else if (reg_wr_in) begin
			if (reg_addr_in[7:4] == BASE_PAGE && reg_addr_in[3:0] < NUM_SEL_L) begin
				nxt_base[reg_addr_in[3:0]] = reg_wdata_in;
			end else if (reg_addr_in[7:4] == OPT_PAGE && reg_addr_in[3:0] < NUM_SEL_L) begin
				nxt_opt[reg_addr_in[3:0]] = reg_wdata_in;
			end else if (reg_addr_in == PINFN_LO_OFS) begin
				for (int i = 0; i < 8; i++)
					nxt_pf[i] = reg_wdata_in[2*i+:2];
			end else if (reg_addr_in == PINFN_HI_OFS) begin
				for (int i = 8; i < NUM_SEL; i++)
					nxt_pf[i] = reg_wdata_in[2*(i-8)+:2];
			end else if (reg_addr_in == LATCH_OFS) begin
				nxt_latch = reg_wdata_in[6:0];
			end
		end
	end

	// Read data for the cycle after the strobe
	always_comb begin
		nxt_rdata = 16'h0000;
		if (reg_rd_in) begin
			if (reg_addr_in[7:4] == BASE_PAGE && reg_addr_in[3:0] < NUM_SEL_L) begin
				nxt_rdata = base_ff[reg_addr_in[3:0]];
			end else if (reg_addr_in[7:4] == OPT_PAGE && reg_addr_in[3:0] < NUM_SEL_L) begin
				nxt_rdata = opt_ff[reg_addr_in[3:0]];
			end else if (reg_addr_in == PINFN_LO_OFS) begin
				for (int i = 0; i < 8; i++)
					nxt_rdata[2*i+:2] = pf_ff[i];
			end else if (reg_addr_in == PINFN_HI_OFS) begin
				for (int i = 8; i < NUM_SEL; i++)
					nxt_rdata[2*(i-8)+:2] = pf_ff[i];
			end else if (reg_addr_in == LATCH_OFS) begin
				nxt_rdata = {9'h000, latch_ff};
			end else if (reg_addr_in == STATUS_OFS) begin
				nxt_rdata = {state_ff, wait_ff, served_ff, slow_clk_ff, 5'h00};
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		base_ff <= nxt_base;
		opt_ff <= nxt_opt;
		pf_ff <= nxt_pf;
		latch_ff <= nxt_latch;
		rdata_ff <= nxt_rdata;
	end

	assign reg_rdata_out = rdata_ff;

	// ****************************************************************
	// Slow bus clock divider
	// ****************************************************************
	always_comb begin
		nxt_slow_cnt = slow_cnt_ff + 3'h1;
		nxt_slow_clk = slow_clk_ff;
		if (srst_in) begin
			nxt_slow_cnt = 3'h0;
			nxt_slow_clk = 1'b0;
		end else if (slow_cnt_ff == SLOW_HALF_CYC - 3'h1) begin
			nxt_slow_cnt = 3'h0;
			nxt_slow_clk = ~slow_clk_ff;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		slow_cnt_ff <= nxt_slow_cnt;
		slow_clk_ff <= nxt_slow_clk;
	end

	assign slow_bus_clock_out = slow_clk_ff;

	// ****************************************************************
	// Select pins
	// ****************************************************************
	// Registered one clock behind the strobe so pins never glitch on decode
	always_ff @(posedge clk_sys_in) begin
		sel_ff <= nxt_sel;
		pin_ff <= nxt_pin;
	end

	assign select_n_out = pin_ff;

	// ****************************************************************
	// Shared acknowledge generator
	// ****************************************************************
	// Lowest numbered match wins; blocks sharing addresses share waits
	always_comb begin
		found = 1'b0;
		pick = BOOT_IDX;
		for (int i = NUM_SEL - 1; i >= 0; i--) begin
			if (match[i]) begin
				found = 1'b1;
				pick = 4'(i);
			end
		end
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_wait = wait_ff;
		nxt_served = served_ff;
		case (state_ff)
			ACK_IDLE: begin
				// Sync mode and the external-only code leave the cycle to the pins
				if (as_act && !as_prev_ff && found && !opt_ff[pick][OPT_MODE_BIT]
					&& opt_ff[pick][OPT_ACK_LSB+:4] != ACK_EXT_ONLY) begin
					nxt_wait = ack_waits(opt_ff[pick][OPT_ACK_LSB+:4]);
					nxt_served = pick;
					nxt_state = ACK_WAIT;
				end
			end
			ACK_WAIT: begin
				// External acknowledge may end the cycle early
				if (!as_act)
					nxt_state = ACK_IDLE;
				else if (wait_ff != 4'h0)
					nxt_wait = wait_ff - 4'h1;
				else if (opt_ff[served_ff][OPT_AUTOVECTOR_ACK_BIT] && iack)
					nxt_state = ACK_AUTO;
				else
					nxt_state = ACK_TERM;
			end
			default: begin
				if (!as_act)
					nxt_state = ACK_IDLE;
			end
		endcase
		if (srst_in) begin
			nxt_state = ACK_IDLE;
			nxt_wait = 4'h0;
			nxt_served = BOOT_IDX;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		state_ff <= nxt_state;
		wait_ff <= nxt_wait;
		served_ff <= nxt_served;
		as_prev_ff <= ~srst_in & as_act;
	end

	// Port width picks which acknowledge line goes low
	assign int_ack_n = (state_ff != ACK_TERM) ? 2'h3
		: ((pf_ff[served_ff] == PF_SEL16) ? 2'h1 : 2'h2);
	assign transfer_ack_n_out = int_ack_n & accept_ff[1:0];
	assign autovector_ack_n_out = (state_ff != ACK_AUTO);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);

	sequence s_wait_done;
		state_ff == ACK_WAIT && wait_ff == 4'h0 && as_act;
	endsequence

	a_onchip_hit_quiet: assert property (internal_hit_in |=> sel_ff == 12'h000)
		else $error("select asserted on an on-chip access");
	a_rw_gating: assert property ((sel_ff & ~$past(rw_ok)) == 12'h000)
		else $error("select asserted against its read/write field");
	a_space_gating: assert property ((sel_ff & ~$past(space_ok)) == 12'h000)
		else $error("select asserted outside its address space");
	a_byte_gating: assert property ((sel_ff & ~$past(byte_ok)) == 12'h000)
		else $error("select asserted on a disabled byte lane");
	a_boot_reset_vals: assert property (@(posedge clk_sys_in) $fell(srst_in)
		|-> base_ff[0] == BOOT_BASE_RST && opt_ff[0][OPT_BYTE_LSB+:2] == 2'h3
		&& opt_ff[1][OPT_BYTE_LSB+:2] == 2'h0)
		else $error("boot or general select reset values wrong");
	a_wait_countdown: assert property (state_ff == ACK_WAIT && wait_ff != 4'h0 && as_act
		|=> state_ff == ACK_WAIT && wait_ff == $past(wait_ff) - 4'h1)
		else $error("internal wait count did not step down");
	a_wait_done_ack: assert property (s_wait_done |=> (state_ff == ACK_TERM
		&& int_ack_n != 2'h3) || (state_ff == ACK_AUTO && !autovector_ack_n_out))
		else $error("internal acknowledge missing after the wait count");
	a_ext_ack_pass: assert property (!accept_ff[1] |-> !transfer_ack_n_out[1])
		else $error("external acknowledge blocked");
	a_latch_bit7_zero: assert property (reg_rd_in && reg_addr_in == LATCH_OFS
		|=> reg_rdata_out[15:7] == 9'h000)
		else $error("latch upper bits not read as zero");
	// Autovector stands one cycle past the strobe, so look at the cycle before
	a_autovector_ack_only_iack: assert property (!autovector_ack_n_out |-> $past(iack) && $past(as_act))
		else $error("autovector outside an acknowledge cycle");

endmodule
`default_nettype wire

/* File: verif/ext_peripheral.sv */
// Behavioural external peripheral that acknowledges one select late
`timescale 1ns/1ps
`default_nettype none
module ext_peripheral (
	// Clock and select
	input wire logic clk_sys_in,
	input wire logic sel_n_in,
	// Answer delay in system clocks
	input wire logic [3:0] delay_in,
	// Acknowledge pins
	output logic [1:0] ack_n_out
);
	// ********
	// Late acknowledge
	// ********
	logic [3:0] cnt_ff = 4'h0;
	logic [1:0] ack_ff = 2'b11;
	assign ack_n_out = ack_ff;
	// Released pins go to the pull-up level; an unknown select counts as released
	always @(posedge clk_sys_in) begin
		if (sel_n_in !== 1'b0) begin
			cnt_ff <= 4'h0;
			ack_ff <= 2'b11;
		end else if (cnt_ff == delay_in) begin
			ack_ff <= 2'b01;
		end else begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking testbench of the chip-select decoder
`timescale 1ns/1ps
`default_nettype none
module tb
	import chip_select_pkg::*;
;
	// ********
	// Stimulus and observed signals
	// ********
	logic clk = 1'b0, srst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, rdn = 1'b1;
	logic as_n = 1'b1, ds_n = 1'b1, hit = 1'b0, sclk, autovector_ack_n;
	logic [7:0] ra = 8'h00, strap = 8'hff;
	logic [15:0] wd = 16'h0000, rdat;
	logic [23:0] addr = 24'h000000;
	logic [2:0] fc = 3'h5;
	logic [1:0] tsz = 2'h2, xack_n, tack_n;
	logic [11:0] sel_n;
	logic [3:0] pdly = 4'h0;
	int errors = 0, check_count = 0, ds_d = 0, tol = 0;

	// Design and far-side model
	chip_select_decoder dut (.clk_sys_in(clk), .srst_in(srst), .reg_addr_in(ra), .reg_wdata_in(wd),
		.reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdat), .addr_in(addr), .function_code_in(fc),
		.read_in(rdn), .transfer_size_in(tsz), .address_strobe_n_in(as_n), .data_strobe_n_in(ds_n),
		.internal_hit_in(hit), .data_strap_in(strap), .ext_transfer_ack_n_in(xack_n),
		.select_n_out(sel_n), .slow_bus_clock_out(sclk), .transfer_ack_n_out(tack_n),
		.autovector_ack_n_out(autovector_ack_n));
	ext_peripheral far (.clk_sys_in(clk), .sel_n_in(sel_n[3]), .delay_in(pdly), .ack_n_out(xack_n));

	// 25 MHz system clock
	initial forever #20 clk = ~clk;

	// ********
	// Compares and verdict
	// ********
	task chk_val(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task chk_cyc(input int g, input int e);
		check_count++;
		if (g != e) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task conclude;
		if (errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ********
	// Expectations
	// ********
	function automatic logic [15:0] opt(input logic m, input logic [1:0] b, rw, input logic s,
		input logic [3:0] k, input logic [1:0] sp, input logic [2:0] l, input logic av);
		return {m, b, rw, s, k, sp, l, av};
	endfunction
	// Boot field follows strap 0; selects 1 to 11 follow strap bit (i+1)/2
	function automatic logic [23:0] pinfn(input logic [7:0] s);
		logic [23:0] f;
		f[1:0] = {1'b1, s[0]};
		for (int i = 1; i < 12; i++) begin
			f[2*i+:2] = {s[(i+1)/2], 1'b1};
		end
		return f;
	endfunction
	function automatic int lsb_of(input logic [2:0] c);
		int t[8] = '{11, 13, 14, 16, 17, 18, 19, 20};
		return t[c];
	endfunction
	// Upper four address bits never reach the comparator
	function automatic logic hit_blk(input logic [23:0] a, input logic [15:0] b);
		logic [23:0] e;
		int l;
		e = {{4{a[19]}}, a[19:0]};
		l = lsb_of(b[2:0]);
		return (e >> l) == ({b[15:3], 11'h000} >> l);
	endfunction
	function automatic int ack_k(input logic [3:0] n);
		return (n == 4'he) ? 2 : n + 2;
	endfunction

	// ********
	// Register port and bus cycles
	// ********
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task rchk(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		ra <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 chk_val(rdat, e);
	endtask
	// Fixed 20-cycle window, so a missing answer shows as a count mismatch
	task bus(input logic [23:0] a, input logic [2:0] f, input logic r, h, input int es, esk, ek,
		input logic [1:0] ea, input int ev);
		logic [11:0] lows;
		logic [1:0] av;
		int sk, ak, vk;
		lows = 12'h000;
		av = 2'h3;
		sk = 0;
		ak = 0;
		vk = 0;
		@(posedge clk);
		addr <= a;
		fc <= f;
		rdn <= r;
		hit <= h;
		as_n <= 1'b0;
		if (ds_d == 0) ds_n <= 1'b0;
		for (int k = 1; k < 21; k++) begin
			@(posedge clk);
			if (k == ds_d) ds_n <= 1'b0;
			#1;
			lows |= ~sel_n;
			if (sk == 0 && sel_n !== 12'hfff) sk = k;
			if (ak == 0 && tack_n !== 2'h3) begin
				ak = k;
				av = tack_n;
			end
			if (vk == 0 && autovector_ack_n !== 1'b1) vk = k;
		end
		@(posedge clk);
		as_n <= 1'b1;
		ds_n <= 1'b1;
		hit <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk_val(sel_n, 12'hfff);
		// Let synchronised external acknowledges drain first
		repeat (4) @(posedge clk);
		chk_val(lows, es == 15 ? 12'h000 : 12'h001 << es);
		chk_cyc(sk, es == 15 ? 0 : esk);
		chk_cyc((ak >= ek && ak <= ek + tol) ? ek : ak, ek);
		chk_val(av, ea);
		chk_cyc(vk, ev);
	endtask
	task mb(input logic [23:0] a, input logic [2:0] f, input logic r, h, input int es, input logic m,
		input int ek, input logic [1:0] ea);
		bus(a, f, r, h, m ? es : 15, 1, m ? ek : 0, m ? ea : 2'h3, 0);
	endtask
	task rst(input logic [7:0] s);
		@(posedge clk);
		strap <= s;
		srst <= 1'b1;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
	endtask

	// ********
	// Main sequence
	// ********
	initial begin
		logic [15:0] d, b;
		logic [23:0] a;
		logic [3:0] k4;
		logic [2:0] p;
		logic m, r, pc;
		int n, fl, tg;
		void'($urandom(10));
		// Reset values, boot fetch, register read-back, twice with a reset between
		for (int j = 0; j < 2; j++) begin
			rst(j ? 8'h5a : 8'hff);
			rchk(STATUS_OFS, 16'h0000);
			rchk(8'h00, 16'h0007);
			rchk(8'h10, opt(0, 3, 3, 0, 13, 2, 0, 0));
			for (int i = 1; i < 12; i++) begin
				rchk(8'(i), 16'h0000);
				rchk(8'h10 + 8'(i), 16'h0000);
			end
			a = pinfn(strap);
			rchk(PINFN_LO_OFS, a[15:0]);
			rchk(PINFN_HI_OFS, {8'h00, a[23:16]});
			rchk(LATCH_OFS, 16'h0000);
			n = $urandom;
			bus({5'h00, n[18:1], 1'b0}, 3'h5, 1, 0, 0, 1, 15, strap[0] ? 2'b01 : 2'b10, 0);
			for (int i = 0; i < 12; i++) begin
				d = 16'($urandom);
				wr(8'(i), d);
				rchk(8'(i), d);
				wr(8'h10 + 8'(i), d);
				rchk(8'h10 + 8'(i), d);
			end
			wr(8'h30, 16'hffff);
			rchk(8'h30, 16'h0000);
		end
		rst(8'hff);
		// Every block size, inside and just outside the block; the two largest flip bit 20 and stay inside
		for (int c = 0; c < 8; c++) begin
			n = $urandom;
			a = {4'hf, 1'b1, n[18:0]};
			b = {a[23:11] & (13'h1fff << (lsb_of(3'(c)) - 11)), 3'(c)};
			k4 = 4'($urandom % 15);
			wr(8'h01, b);
			wr(8'h11, opt(0, 3, 3, 0, k4, 2, 0, 0));
			bus({n[31:28], a[19:0]}, 3'h5, 1, 0, 1, 1, ack_k(k4), 2'b01, 0);
			fl = lsb_of(3'(c)) >= 19 ? 20 : lsb_of(3'(c));
			a = a ^ (24'h1 << fl);
			mb(a, 3'h5, 1, 0, 1, hit_blk(a, b), ack_k(k4), 2'b01);
		end
		// Read/write and space fields
		wr(8'h01, 16'hf803);
		for (int j = 0; j < 24; j++) begin
			r = 1'($urandom);
			wr(8'h11, opt(0, 3, 2'(j / 8 + 1), 0, 4'he, 2'(j / 2), 0, 0));
			m = (r ? (j / 8 + 1) % 2 : (j / 8 + 1) / 2) && ((j / 2) % 4 == 3 || (j / 2) % 4 == 1 + j % 2);
			mb(24'hf81234, j % 2 ? 3'h5 : 3'h1, r, 0, 1, m, 2, 2'b01);
		end
		// Byte lanes on both port widths
		tsz <= 2'h1;
		for (int j = 0; j < 16; j++) begin
			wr(PINFN_LO_OFS, {12'hfff, 2'(2 + j / 8), 2'h3});
			wr(8'h11, opt(0, 2'(j / 2), 3, 0, 4'he, 2, 0, 0));
			m = (j / 2) % 4 != 0 && (j < 8 || (j / 2) % 4 == 3 || ((j / 2) % 4 == 2) == (j % 2 == 0));
			mb({20'hf8123, 3'h2, 1'(j)}, 3'h5, 1, 0, 1, m, 2, j < 8 ? 2'b10 : 2'b01);
		end
		wr(PINFN_LO_OFS, 16'hffff);
		// On-chip hit, then data strobe timing
		wr(8'h11, opt(0, 3, 3, 0, 4'he, 2, 0, 0));
		mb(24'hf81234, 3'h5, 1, 1, 1, 0, 2, 2'b01);
		wr(8'h11, opt(0, 3, 3, 1, 4'he, 2, 0, 0));
		ds_d = 3;
		bus(24'hf81234, 3'h5, 1, 0, 1, 4, 2, 2'b01, 0);
		ds_d = 0;
		// Interrupt acknowledge: level match and autovector
		wr(8'h02, 16'hfffb);
		for (int i = 0; i < 8; i++) begin
			n = $urandom;
			p = n[0] ? 3'(i) : n[3:1];
			m = i == 0 || p == 3'(i);
			wr(8'h12, opt(0, 1, 1, 0, 1, 0, 3'(i), n[4]));
			bus({20'hfffff, p, 1'b1}, 3'h7, 1, 0, m ? 2 : 15, 1, m && !n[4] ? 3 : 0,
				m && !n[4] ? 2'b01 : 2'b11, m && n[4] ? 3 : 0);
		end
		tsz <= 2'h2;
		// External acknowledge, prompt and slow, with and without internal one
		// Select 3 keeps a block of its own, so wait counts never clash
		wr(8'h03, 16'hf903);
		tol = 2;
		for (int j = 0; j < 4; j++) begin
			pdly <= j > 1 ? 4'h5 : 4'h0;
			wr(8'h13, opt(0, 3, 3, 0, j % 2 ? 4'hd : 4'hf, 2, 0, 0));
			bus(24'hf91234, 3'h5, 1, 0, 3, 1, (j > 1 ? 5 : 0) + 4, 2'b01, 0);
		end
		tol = 0;
		// Slow-clock mode: select follows the slow clock, strobe bit ignored
		wr(8'h11, opt(1, 3, 3, 1, 4'he, 2, 0, 0));
		@(posedge clk);
		addr <= 24'hf81234;
		as_n <= 1'b0;
		#1 pc = sclk;
		tg = 0;
		for (int k = 0; k < 24; k++) begin
			@(posedge clk);
			#1 chk_val(sel_n[1], !pc);
			chk_val(tack_n, 2'h3);
			if (sclk !== pc) tg++;
			pc = sclk;
		end
		// Slow clock toggles once per half period, whatever its phase
		chk_cyc(tg, 24 / int'(SLOW_HALF_CYC));
		@(posedge clk);
		as_n <= 1'b1;
		// Plain-output pins follow the latch, bit 7 stays zero
		wr(PINFN_LO_OFS, 16'h00ff);
		wr(PINFN_HI_OFS, 16'h0040);
		repeat (2) begin
			d = 16'($urandom);
			wr(LATCH_OFS, d);
			rchk(LATCH_OFS, {9'h000, d[6:0]});
			chk_val(sel_n, {1'b1, d[6:0], 4'hf});
		end
		conclude;
	end
endmodule
`default_nettype wire
